/* File: pusr_device.sv */
// Sensor end: power-up line signalling, report sequencing, checksum and serial transmitter.
// How it works
// - 1200 baud, start, eight data LSB first, stop.
// - Line goes high within 100 ms of power.
// - Line held low while measuring.
// - Line idles high between announce and first start.
// - Character timing begins only at first start bit.
// - Report sent unprompted when measurements complete.
// - Command mode entered after report.
// - One power-up report per power cycle.
// - Logger starts each transfer by switching supply.
// - No report when stored address is nonzero.
// - Stored address resets to zero.
// - Order: tab, values with spaces, CR, type, checksum.
// - Sensor type is one fixed character.
// - Checksum spans report start through type, no address.
// - Sum through CR plus type, mod 64, plus 32.
// - Continuous-read replies reuse the same checksum.
// - Conductivity in microsiemens per centimetre at 25 C.
// - Count field one digit or two with zero.
// - Time field is exactly three digits.
`timescale 1ns/100ps
`default_nettype none
module pusr_device #(
  parameter int BIT_CYC  = pusr_pkg::BIT_CYCLES,
  parameter int HIGH_CYC = pusr_pkg::HIGH_CYCLES
) (
  input  wire logic                                         clk,
  input  wire logic                                         reset_n,
  pusr_if.device                                            link,
  input  wire logic                                         meas_phase_done,
  input  wire logic                                         meas_done,
  input  wire logic [8*pusr_pkg::TEXT_CHARS-1:0]            perm_text,
  input  wire logic [pusr_pkg::LEN_W-1:0]                   perm_len,
  input  wire logic [8*pusr_pkg::TEXT_CHARS-1:0]            temp_text,
  input  wire logic [pusr_pkg::LEN_W-1:0]                   temp_len,
  input  wire logic [8*pusr_pkg::TEXT_CHARS-1:0]            cond_text,
  input  wire logic [pusr_pkg::LEN_W-1:0]                   cond_len,
  input  wire logic                                         addr_wr,
  input  wire logic [7:0]                                   addr_wdata,
  input  wire logic                                         cont_req,
  input  wire logic [6:0]                                   meas_count,
  input  wire logic                                         count_two_digit,
  input  wire logic [9:0]                                   max_time_s,
  output var  logic                                         report_busy,
  output var  logic                                         cmd_mode,
  output var  logic [7:0]                                   addr_out,
  output var  logic [15:0]                                  count_field,
  output var  logic [23:0]                                  ttt_field
);
  import pusr_pkg::*;

  localparam logic [31:0]           HIGH_LAST = 32'(HIGH_CYC - 1);
  localparam logic [3:0]            BITS_LOAD = 4'(FRAME_BITS);
  localparam logic [FRAME_BITS-1:0] SH_IDLE   = '1;

  typedef struct packed {
    pusr_dstate_e          st;
    logic                  line;
    logic                  sent;
    logic                  cont;
    logic [7:0]            addr;
    pusr_field_e           fld;
    logic [LEN_W-1:0]      idx;
    logic [7:0]            sum;
    logic                  tx_busy;
    logic [FRAME_BITS-1:0] sh;
    logic [3:0]            bits;
    logic [31:0]           tmr;
    logic                  busy_o;
    logic                  cmd_o;
    logic [15:0]           cnt_f;
    logic [23:0]           ttt_f;
  } pusr_dev_s;

  localparam pusr_dev_s DEV_RST = '{st: DS_OFF, fld: F_TAB, addr: CH_ZERO, sh: SH_IDLE,
                                    default: '0};

  pusr_dev_s        r;
  pusr_dev_s        n;
  logic             tx_load;
  logic             tick;
  logic [7:0]       b;
  logic [LEN_W-1:0] len;
  logic             is_val;

  // Shared bit-period divider, restarted as each character begins.
  pusr_baud_div #(.DIV(BIT_CYC)) u_div (
    .clk     (clk),
    .reset_n (reset_n),
    .restart (tx_load),
    .half    (1'b0),
    .tick    (tick)
  );

  // Next-state logic for sequencing, transmitter and response fields.
  always_comb begin
    n       = r;
    tx_load = 1'b0;
    b       = 8'h00;
    len     = '0;
    is_val  = 1'b0;
    n.cnt_f = pusr_fmt_count(meas_count, count_two_digit);
    n.ttt_f = pusr_fmt_secs(max_time_s);
    if (addr_wr && r.st == DS_CMD) begin
      n.addr = addr_wdata;
    end
    // Shifts out one bit per tick, start bit first, data LSB first, then stop.
    if (r.tx_busy && tick) begin
      n.sh   = {1'b1, r.sh[FRAME_BITS-1:1]};
      n.line = r.sh[1];
      n.bits = r.bits - 1'b1;
      if (r.bits == 4'h1) begin
        n.tx_busy = 1'b0;
      end
    end
    // Picks the current field's character and its length.
    case (r.fld)
      F_ADDR:  b = r.addr;
      F_TAB:   b = CH_TAB;
      F_PERM:  begin b = perm_text[8*r.idx +: 8]; len = perm_len; is_val = 1'b1; end
      F_SP1:   b = CH_SP;
      F_TEMP:  begin b = temp_text[8*r.idx +: 8]; len = temp_len; is_val = 1'b1; end
      F_SP2:   b = CH_SP;
      F_COND:  begin b = cond_text[8*r.idx +: 8]; len = cond_len; is_val = 1'b1; end
      F_CR:    b = CH_CR;
      F_TYPE:  b = SENSOR_TYPE;
      F_CKS:   b = pusr_cks(r.sum);
      default: b = CH_SP;
    endcase
    case (r.st)
      DS_OFF: begin
        n.line = 1'b0;
        n.st   = DS_LOW;
      end
      DS_LOW: begin
        n.line = 1'b0;
        n.tmr  = r.tmr + 1'b1;
        if (meas_phase_done || r.tmr >= HIGH_LAST) begin
          n.line = 1'b1;
          n.st   = DS_HIGH;
        end
      end
      DS_HIGH: begin
        n.line = 1'b1;
        if (meas_done) begin
          if (r.sent || r.addr != CH_ZERO) begin
            n.st = DS_CMD;
          end else begin
            n.st   = DS_SEND;
            n.fld  = F_TAB;
            n.idx  = '0;
            n.sum  = 8'h00;
            n.cont = 1'b0;
          end
        end
      end
      DS_SEND: begin
        if (!r.tx_busy) begin
          if (r.fld == F_END) begin
            n.st   = DS_CMD;
            n.sent = r.sent | !r.cont;
          end else if (is_val && r.idx >= len) begin
            n.fld = pusr_field_e'(r.fld + 4'h1);
            n.idx = '0;
          end else begin
            tx_load   = 1'b1;
            n.tx_busy = 1'b1;
            n.sh      = {1'b1, b, 1'b0};
            n.bits    = BITS_LOAD;
            n.line    = 1'b0;
            if (r.fld != F_ADDR && r.fld != F_CKS) begin
              n.sum = r.sum + b;
            end
            if (is_val && r.idx + 1'b1 < len) begin
              n.idx = r.idx + 1'b1;
            end else begin
              n.fld = pusr_field_e'(r.fld + 4'h1);
              n.idx = '0;
            end
          end
        end
      end
      DS_CMD: begin
        if (!r.tx_busy) begin
          n.line = 1'b1;
        end
        if (cont_req && !r.tx_busy) begin
          n.st   = DS_SEND;
          n.fld  = F_ADDR;
          n.idx  = '0;
          n.sum  = 8'h00;
          n.cont = 1'b1;
        end
      end
      default: n.st = DS_OFF;
    endcase
    // Loss of supply returns everything but the stored address to power-up state.
    if (!link.power_on) begin
      n       = DEV_RST;
      n.addr  = r.addr;
      tx_load = 1'b0;
    end
    n.busy_o = (n.st == DS_SEND);
    n.cmd_o  = (n.st == DS_CMD);
  end

  // State register; the address leaves reset at zero.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= DEV_RST;
    end else begin
      r <= n;
    end
  end

  assign link.sdata  = r.line;
  assign report_busy = r.busy_o;
  assign cmd_mode    = r.cmd_o;
  assign addr_out    = r.addr;
  assign count_field = r.cnt_f;
  assign ttt_field   = r.ttt_f;
endmodule : pusr_device
`default_nettype wire

/* File: pusr_pkg.sv */
// Shared constants, types and formatting functions for the power-up serial report link.
package pusr_pkg;

  // Clock and link timing.
  localparam int CLK_HZ      = 250_000_000;
  localparam int BAUD        = 1200;
  localparam int BIT_CYCLES  = CLK_HZ / BAUD;
  localparam int HIGH_MS     = 100;
  localparam int HIGH_CYCLES = (CLK_HZ / 1000) * HIGH_MS;

  // Character framing: start, eight data bits, stop.
  localparam int DATA_BITS  = 8;
  localparam int FRAME_BITS = 10;

  // Fixed characters of the report.
  localparam logic [7:0] CH_TAB      = 8'h09;
  localparam logic [7:0] CH_SP       = 8'h20;
  localparam logic [7:0] CH_CR       = 8'h0d;
  localparam logic [7:0] CH_ZERO     = 8'h30;
  localparam logic [7:0] SENSOR_TYPE = 8'h61; // Value is arbitrary.

  // Checksum: low six bits of the sum, lifted into the printable range.
  localparam int         CKS_BITS = 6;
  localparam logic [7:0] CKS_OFS  = 8'h20;

  // Value text fields: up to eight characters each.
  localparam int TEXT_CHARS = 8;
  localparam int LEN_W      = 4;

  // Response field formatting.
  localparam int RADIX    = 10;
  localparam int SECS_MAX = 999;

  // Report fields in transmit order.
  typedef enum logic [3:0] {
    F_ADDR = 4'h0, F_TAB = 4'h1, F_PERM = 4'h2, F_SP1 = 4'h3, F_TEMP = 4'h4,
    F_SP2  = 4'h5, F_COND = 4'h6, F_CR = 4'h7, F_TYPE = 4'h8, F_CKS = 4'h9,
    F_END  = 4'ha
  } pusr_field_e;

  // Device end states, Gray coded along the power-up path.
  typedef enum logic [2:0] {
    DS_OFF = 3'h0, DS_LOW = 3'h1, DS_HIGH = 3'h3, DS_SEND = 3'h2, DS_CMD = 3'h6
  } pusr_dstate_e;

  // Receiver end states, Gray coded along the receive path.
  typedef enum logic [2:0] {
    HS_OFF = 3'h0, HS_ARM = 3'h1, HS_START = 3'h3, HS_DATA = 3'h2, HS_STOP = 3'h6,
    HS_DONE = 3'h7
  } pusr_hstate_e;

  // Turns a running byte sum into the printable checksum character.
  function automatic logic [7:0] pusr_cks(input logic [7:0] sum);
    pusr_cks = {{(8 - CKS_BITS){1'b0}}, sum[CKS_BITS-1:0]} + CKS_OFS;
  endfunction : pusr_cks

  // One ASCII decimal digit of a value.
  function automatic logic [7:0] pusr_digit(input int v);
    pusr_digit = CH_ZERO + 8'(v % RADIX);
  endfunction : pusr_digit

  // Measurement count, one digit in the low byte or two digits with leading zero.
  function automatic logic [15:0] pusr_fmt_count(input logic [6:0] n, input logic two);
    int v;
    v = int'(n);
    pusr_fmt_count = two ? {pusr_digit(v / RADIX), pusr_digit(v)} : {8'h00, pusr_digit(v)};
  endfunction : pusr_fmt_count

  // Whole seconds as exactly three digits, most significant first.
  function automatic logic [23:0] pusr_fmt_secs(input logic [9:0] s);
    int v;
    v = (int'(s) > SECS_MAX) ? SECS_MAX : int'(s);
    pusr_fmt_secs = {pusr_digit(v / (RADIX * RADIX)), pusr_digit(v / RADIX), pusr_digit(v)};
  endfunction : pusr_fmt_secs

endpackage : pusr_pkg

/* File: pusr_if.sv */
// Link between the sensor end and the logger end: supply switch and serial data line.
`timescale 1ns/100ps
`default_nettype none
interface pusr_if;
  logic power_on; // Sensor supply, driven by the logger.
  logic sdata;    // Serial data line, driven by the sensor.

  modport device (input power_on, output sdata);
  modport host   (output power_on, input sdata);
endinterface : pusr_if
`default_nettype wire

/* File: pusr_baud_div.sv */
// Bit-rate divider that yields a one-cycle tick and restarts on demand.
`timescale 1ns/100ps
`default_nettype none
module pusr_baud_div #(
  parameter int DIV = 208333
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic restart,
  input  wire logic half,
  output var  logic tick
);
  import pusr_pkg::*;

  localparam int            CW     = $clog2(DIV);
  localparam logic [CW-1:0] RELOAD = CW'(DIV - 1);
  localparam logic [CW-1:0] HALF   = CW'(DIV / 2 - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
  } pusr_div_s;

  pusr_div_s r;
  pusr_div_s n;

  // Counts down and reloads; a restart aligns the count to a new frame edge.
  always_comb begin
    n = r;
    if (restart) begin
      n.cnt = half ? HALF : RELOAD;
    end else if (r.cnt == '0) begin
      n.cnt = RELOAD;
    end else begin
      n.cnt = r.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // A tick marks the end of a bit period, or the middle of one after a restart with half set.
  assign tick = (r.cnt == '0) && !restart;
endmodule : pusr_baud_div
`default_nettype wire

/* File: pusr_host.sv */
// Logger end: switches sensor supply and receives and checks the power-up report.
`timescale 1ns/100ps
`default_nettype none
module pusr_host #(
  parameter int BIT_CYC = pusr_pkg::BIT_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       reset_n,
  pusr_if.host            link,
  input  wire logic       power_req,
  output var  logic [7:0] rx_data,
  output var  logic       rx_valid,
  output var  logic       frame_err,
  output var  logic       report_done,
  output var  logic       report_ok,
  output var  logic [7:0] sensor_type
);
  import pusr_pkg::*;

  localparam logic [3:0] DATA_LAST = 4'(DATA_BITS - 1);
  localparam logic [1:0] PH_BODY   = 2'h0;
  localparam logic [1:0] PH_TYPE   = 2'h1;
  localparam logic [1:0] PH_CKS    = 2'h2;

  typedef struct packed {
    pusr_hstate_e st;
    logic         pwr;
    logic         seen_high;
    logic [7:0]   sh;
    logic [3:0]   cnt;
    logic [7:0]   sum;
    logic [1:0]   phase;
    logic [7:0]   rx_data;
    logic         rx_valid;
    logic         ferr;
    logic         done;
    logic         ok;
    logic [7:0]   stype;
  } pusr_host_s;

  localparam pusr_host_s HOST_RST = '{st: HS_OFF, default: '0};

  pusr_host_s r;
  pusr_host_s n;
  logic       restart;
  logic       tick;

  // Divider restarted at a start edge so ticks fall mid-bit.
  pusr_baud_div #(.DIV(BIT_CYC)) u_div (
    .clk     (clk),
    .reset_n (reset_n),
    .restart (restart),
    .half    (1'b1),
    .tick    (tick)
  );

  // Receive sequencing, checksum tracking and supply control.
  always_comb begin
    n          = r;
    restart    = 1'b0;
    n.rx_valid = 1'b0;
    n.ferr     = 1'b0;
    n.done     = 1'b0;
    n.pwr      = power_req;
    case (r.st)
      HS_OFF: begin
        if (r.pwr) begin
          n.st = HS_ARM;
        end
      end
      HS_ARM: begin
        // Low levels before the line has been seen high are not characters.
        if (link.sdata) begin
          n.seen_high = 1'b1;
        end else if (r.seen_high) begin
          restart = 1'b1;
          n.st    = HS_START;
        end
      end
      HS_START: begin
        if (tick) begin
          n.cnt = 4'h0;
          n.st  = link.sdata ? HS_ARM : HS_DATA;
        end
      end
      HS_DATA: begin
        if (tick) begin
          n.sh  = {link.sdata, r.sh[7:1]};
          n.cnt = r.cnt + 1'b1;
          if (r.cnt == DATA_LAST) begin
            n.st = HS_STOP;
          end
        end
      end
      HS_STOP: begin
        if (tick) begin
          n.st = HS_ARM;
          if (!link.sdata) begin
            n.ferr      = 1'b1;
            n.seen_high = 1'b0;
          end else begin
            n.rx_data  = r.sh;
            n.rx_valid = 1'b1;
            case (r.phase)
              PH_BODY: begin
                n.sum = r.sum + r.sh;
                if (r.sh == CH_CR) begin
                  n.phase = PH_TYPE;
                end
              end
              PH_TYPE: begin
                n.sum   = r.sum + r.sh;
                n.stype = r.sh;
                n.phase = PH_CKS;
              end
              default: begin
                n.ok   = (r.sh == pusr_cks(r.sum));
                n.done = 1'b1;
                n.st   = HS_DONE;
              end
            endcase
          end
        end
      end
      HS_DONE: n.st = HS_DONE;
      default: n.st = HS_OFF;
    endcase
    // Removing supply ends the cycle; the next report needs a fresh power-up.
    if (!r.pwr) begin
      n       = HOST_RST;
      n.pwr   = power_req;
      restart = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= HOST_RST;
    end else begin
      r <= n;
    end
  end

  assign link.power_on = r.pwr;
  assign rx_data       = r.rx_data;
  assign rx_valid      = r.rx_valid;
  assign frame_err     = r.ferr;
  assign report_done   = r.done;
  assign report_ok     = r.ok;
  assign sensor_type   = r.stype;
endmodule : pusr_host
`default_nettype wire

/* File: pusr_monitor.sv */
// Checker that watches the supply switch and the serial line between the two ends.
`timescale 1ns/100ps
`default_nettype none
module pusr_monitor
  import pusr_pkg::*;
#(
  parameter int BIT_CYC  = BIT_CYCLES,
  parameter int HIGH_CYC = HIGH_CYCLES
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic power_on,
  input  wire logic sdata
);
  localparam int LOW_MAX = HIGH_CYC + 4;
  localparam int MID     = BIT_CYC / 2;

  typedef struct packed {
    logic        inf;
    logic [31:0] fc;
    logic        prev;
    logic [7:0]  sh;
    logic        seen_high;
    logic [27:0] low_cnt;
    logic        byte_v;
    logic [7:0]  rx_byte;
    logic [7:0]  sum;
    logic [1:0]  ph;
    logic        first_done;
    logic        after_cks;
  } pusr_mon_s;

  pusr_mon_s mon_r;
  pusr_mon_s mon_nxt;

  // Rebuilds characters from the line and keeps a running checksum of each report.
  always_comb begin
    mon_nxt = mon_r;
    mon_nxt.byte_v = 1'h0;
    mon_nxt.prev = sdata;
    mon_nxt.seen_high = mon_r.seen_high | sdata;
    if (!mon_nxt.seen_high) mon_nxt.low_cnt = mon_r.low_cnt + 28'h1;
    if (!mon_r.inf) begin
      if (mon_r.prev && !sdata) begin
        mon_nxt.inf = 1'h1;
        mon_nxt.fc = 32'h1;
      end
    end else begin
      mon_nxt.fc = mon_r.fc + 32'h1;
      if (int'(mon_r.fc) % BIT_CYC == MID && int'(mon_r.fc) < 9 * BIT_CYC)
        mon_nxt.sh = {sdata, mon_r.sh[7:1]};
      if (int'(mon_r.fc) == 9 * BIT_CYC + MID) begin
        mon_nxt.byte_v = 1'h1;
        mon_nxt.rx_byte = mon_r.sh;
      end
      if (int'(mon_r.fc) == 10 * BIT_CYC - 1) mon_nxt.inf = 1'h0;
    end
    if (mon_r.byte_v) begin
      mon_nxt.first_done = 1'h1;
      mon_nxt.after_cks = 1'h0;
      mon_nxt.sum = mon_r.sum + mon_r.rx_byte;
      case (mon_r.ph)
        2'h0: begin
          mon_nxt.sum = CH_TAB;
          if (mon_r.rx_byte == CH_TAB) mon_nxt.ph = 2'h1;
        end
        2'h1: if (mon_r.rx_byte == CH_CR) mon_nxt.ph = 2'h2;
        2'h2: mon_nxt.ph = 2'h3;
        default: begin
          mon_nxt.ph = 2'h0;
          mon_nxt.after_cks = 1'h1;
        end
      endcase
    end
    if (!power_on) mon_nxt = '0;
  end

  // Holds the rebuilt state; an unpowered sensor clears it.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) mon_r <= '0;
    else mon_r <= mon_nxt;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence power_rise;
    $rose(power_on);
  endsequence
  sequence held_low;
    !sdata [*2];
  endsequence

  off_line_low_a: assert property (!power_on |=> !sdata)
    else $error("line not low while unpowered");
  early_low_a: assert property (power_rise |-> held_low)
    else $error("line not low right after power up");
  raise_time_a: assert property (power_on |-> mon_r.low_cnt <= LOW_MAX)
    else $error("line not raised in time");
  start_low_a: assert property (mon_r.inf && mon_r.fc < BIT_CYC |-> !sdata)
    else $error("start bit not low for a full bit");
  stop_high_a: assert property (mon_r.inf && mon_r.fc >= 9 * BIT_CYC |-> sdata)
    else $error("stop bit not high");
  bit_edge_a: assert property (mon_r.inf && $changed(sdata) |-> mon_r.fc % BIT_CYC == 0)
    else $error("line changed off a bit boundary");
  first_tab_a: assert property (mon_r.byte_v && !mon_r.first_done |-> mon_r.rx_byte == CH_TAB)
    else $error("first character is not a tab");
  type_char_a: assert property (mon_r.byte_v && mon_r.ph == 2'h2 |-> mon_r.rx_byte == SENSOR_TYPE)
    else $error("wrong sensor type character");
  checksum_a: assert property (mon_r.byte_v && mon_r.ph == 2'h3 |->
    mon_r.rx_byte == {2'h0, mon_r.sum[5:0]} + 8'h20) else $error("wrong checksum character");
  one_report_a: assert property (mon_r.byte_v && mon_r.after_cks |-> mon_r.rx_byte != CH_TAB)
    else $error("second report without power cycle");
endmodule : pusr_monitor
`default_nettype wire

/* File: tb_powerup_serial_report_tx.sv */
// Self-checking bench: sensor end and logger end joined by their link.
`timescale 1ns/100ps
`default_nettype none
module tb_powerup_serial_report_tx;
  import pusr_pkg::*;
  localparam int BITC  = 8;
  localparam int HIGHC = 50;

  logic        clk, reset_n, power_req, meas_phase_done, meas_done, addr_wr, cont_req;
  logic        count_two_digit, report_busy, cmd_mode, rx_valid, frame_err, report_done;
  logic        report_ok;
  logic [7:0]  addr_wdata, addr_out, rx_data, sensor_type;
  logic [6:0]  meas_count;
  logic [9:0]  max_time_s;
  logic [63:0] perm_text, temp_text, cond_text;
  logic [3:0]  perm_len, temp_len, cond_len;
  logic [15:0] count_field;
  logic [23:0] ttt_field;
  logic [7:0]  rxq[$];
  int          num_errors;
  int          n_compared;
  int          n_ferr;

  pusr_if link_if ();
  pusr_device #(.BIT_CYC(BITC), .HIGH_CYC(HIGHC)) pusr_device_inst (
    .clk(clk), .reset_n(reset_n), .link(link_if), .meas_phase_done(meas_phase_done),
    .meas_done(meas_done), .perm_text(perm_text), .perm_len(perm_len),
    .temp_text(temp_text), .temp_len(temp_len), .cond_text(cond_text), .cond_len(cond_len),
    .addr_wr(addr_wr), .addr_wdata(addr_wdata), .cont_req(cont_req), .meas_count(meas_count),
    .count_two_digit(count_two_digit), .max_time_s(max_time_s), .report_busy(report_busy),
    .cmd_mode(cmd_mode), .addr_out(addr_out), .count_field(count_field), .ttt_field(ttt_field));
  pusr_host #(.BIT_CYC(BITC)) pusr_host_inst (
    .clk(clk), .reset_n(reset_n), .link(link_if), .power_req(power_req), .rx_data(rx_data),
    .rx_valid(rx_valid), .frame_err(frame_err), .report_done(report_done),
    .report_ok(report_ok), .sensor_type(sensor_type));
  pusr_monitor #(.BIT_CYC(BITC), .HIGH_CYC(HIGHC)) pusr_monitor_inst (
    .clk(clk), .reset_n(reset_n), .power_on(link_if.power_on), .sdata(link_if.sdata));

  // Clock of 4 ns period.
  always #2 clk = ~clk;

  // Collects every character the logger end takes in, and counts framing errors.
  always @(negedge clk) begin
    if (rx_valid === 1'h1) rxq.push_back(rx_data);
    if (frame_err === 1'h1) n_ferr++;
  end

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("FAIL %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask : chk

  task automatic step(input int k);
    repeat (k) @(negedge clk);
  endtask : step

  function automatic bit probe(input int sel);
    case (sel)
      0: return report_done === 1'h1;
      1: return link_if.sdata === 1'h1;
      2: return report_busy === 1'h1;
      3: return cmd_mode === 1'h1;
      default: return report_busy === 1'h0;
    endcase
  endfunction : probe

  // Bounded wait on a completion condition; running out ends the run.
  task automatic wait_for(input int sel, input int lim);
    for (int i = 0; i < lim && !probe(sel); i++) step(1);
    if (!probe(sel)) begin
      $display("FAIL wait %0d expected 1 seen 0", sel);
      num_errors++;
      print_verdict();
    end
  endtask : wait_for

  // One-cycle pulse on a request input.
  task automatic pulse(input int sel);
    case (sel)
      0: meas_phase_done = 1'h1;
      1: meas_done = 1'h1;
      2: cont_req = 1'h1;
      default: addr_wr = 1'h1;
    endcase
    step(1);
    {meas_phase_done, meas_done, cont_req, addr_wr} = 4'h0;
  endtask : pulse

  function automatic logic [63:0] pack(input string s);
    pack = '0;
    for (int i = 0; i < s.len(); i++) pack[8*i +: 8] = s[i];
  endfunction : pack

  // Powers the sensor and waits for the line to announce a report.
  task automatic power_up(input bit early);
    power_req = 1'h1;
    step(10);
    chk("line while measuring", 1'h0, link_if.sdata);
    if (early) pulse(0);
    wait_for(1, HIGHC + 20);
    step(30);
    chk("line before report", 1'h1, link_if.sdata);
    chk("busy before report", 1'h0, report_busy);
  endtask : power_up

  task automatic power_off();
    power_req = 1'h0;
    step(5);
    chk("line after power off", 1'h0, link_if.sdata);
    chk("command mode unpowered", 1'h0, cmd_mode);
  endtask : power_off

  // Full power-up report, compared character by character at the logger end.
  task automatic t_report(input string p, input string t, input string c);
    string s;
    int    sum;
    s = {"\t", p, " ", t, " ", c, "\015"};
    sum = SENSOR_TYPE;
    for (int i = 0; i < s.len(); i++) sum += s[i];
    perm_text = pack(p);
    perm_len = 4'(p.len());
    temp_text = pack(t);
    temp_len = 4'(t.len());
    cond_text = pack(c);
    cond_len = 4'(c.len());
    rxq.delete();
    power_up(1'h1);
    pulse(1);
    wait_for(0, 3000);
    step(1);
    chk("framing errors", 0, n_ferr);
    chk("report length", 32'(s.len() + 2), 32'(rxq.size()));
    for (int i = 0; i < s.len(); i++) chk("report char", s[i], rxq[i]);
    chk("type char", SENSOR_TYPE, rxq[s.len()]);
    chk("checksum", 32'(sum % 64 + 32), rxq[s.len() + 1]);
    chk("report ok", 1'h1, report_ok);
    chk("type seen", SENSOR_TYPE, sensor_type);
    wait_for(3, 20);
  endtask : t_report

  // The line stays idle in command mode with no further report.
  task automatic t_quiet();
    int lows;
    lows = 0;
    repeat (40 * BITC) begin
      step(1);
      if (link_if.sdata !== 1'h1) lows++;
    end
    chk("low cycles after report", 0, lows);
    chk("command mode held", 1'h1, cmd_mode);
  endtask : t_quiet

  // Count and time fields of command responses.
  task automatic t_fields();
    logic [6:0]  mc[3] = '{7'h07, 7'h2a, 7'h03};
    logic        tw[3] = '{1'h0, 1'h1, 1'h1};
    logic [9:0]  ms[3] = '{10'h005, 10'h078, 10'h3e7};
    logic [15:0] ec[3] = '{16'h0037, 16'h3432, 16'h3033};
    logic [23:0] et[3] = '{24'h303035, 24'h313230, 24'h393939};
    for (int k = 0; k < 3; k++) begin
      meas_count = mc[k];
      count_two_digit = tw[k];
      max_time_s = ms[k];
      step(2);
      chk("count field", ec[k], count_field);
      chk("time field", et[k], ttt_field);
    end
  endtask : t_fields

  // Continuous-read reply; its checksum is judged by the checker.
  task automatic t_cont();
    pulse(2);
    wait_for(2, 10);
    wait_for(4, 3000);
    chk("command mode after reply", 1'h1, cmd_mode);
  endtask : t_cont

  // A nonzero stored address suppresses the report until set back to zero.
  task automatic t_addr();
    addr_wdata = 8'h33;
    pulse(3);
    step(2);
    chk("stored address", 8'h33, addr_out);
    power_off();
    power_up(1'h0);
    pulse(1);
    t_quiet();
    addr_wdata = 8'h30;
    pulse(3);
    step(2);
    chk("address restored", 8'h30, addr_out);
    power_off();
  endtask : t_addr

  initial begin
    clk = 1'h0;
    reset_n = 1'h0;
    power_req = 1'h0;
    {meas_phase_done, meas_done, cont_req, addr_wr, count_two_digit} = 5'h00;
    addr_wdata = 8'h30;
    meas_count = 7'h00;
    max_time_s = 10'h000;
    {perm_text, temp_text, cond_text} = '0;
    {perm_len, temp_len, cond_len} = 12'h000;
    num_errors = 0;
    n_compared = 0;
    n_ferr = 0;
    repeat (5) @(negedge clk);
    reset_n = 1'h1;
    chk("address after reset", 8'h30, addr_out);
    t_report("1.91", "22.6", "1");
    t_quiet();
    t_fields();
    t_cont();
    t_addr();
    t_report("80.25", "-3.5", "1234");
    print_verdict();
  end
endmodule : tb_powerup_serial_report_tx
`default_nettype wire
